// File: dtpio_pkg.sv
// shared constants for the direct / teleprotection point mapper
package dtpio_pkg;
    localparam int unsigned DIR_POINTS   = 32;
    localparam int unsigned OPND_W       = 8;
    localparam int unsigned NUM_OPNDS    = 128;
    localparam int unsigned NODE_W       = 4;
    localparam int unsigned NUM_NODES    = 16;
    localparam int unsigned BIT_W        = 5;
    localparam int unsigned TELE_POINTS  = 16;
    localparam int unsigned DIRIN_SEL_BASE = 96;
    localparam int unsigned SYNC_STAGES  = 2;
    localparam logic        RESET_BIT    = 1'b0;

    typedef enum logic [1:0] {
        DTPIO_DEF_ON        = 2'h0,
        DTPIO_DEF_OFF       = 2'h1,
        DTPIO_DEF_LATEST_ON = 2'h2,
        DTPIO_DEF_LATEST_OFF= 2'h3
    } dtpio_default_t;
endpackage

// File: dtpio_sync.sv
// two-stage synchroniser for a bus of pin-level inputs
`timescale 1ns/1ps
module dtpio_sync
    import dtpio_pkg::*;
#(
    parameter int unsigned WIDTH = 1
)(
    // clock and reset
    input  wire logic             clock_in,
    input  wire logic             rst_in,
    // data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            stage1   <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // dtpio_sync

// File: dtpio_fail_hold.sv
// one fail-safe point: default, hold-last, or follow
`timescale 1ns/1ps
module dtpio_fail_hold
    import dtpio_pkg::*;
(
    // clock and reset
    input  wire logic     clock_in,
    input  wire logic     rst_in,
    // point
    input  wire logic     enable_in,
    input  wire logic     link_ok_in,
    input  wire logic     rx_bit_in,
    input  wire logic [1:0] fail_default_in,
    output logic          point_out
);
    logic held;
    logic known;
    wire  logic unknown_val;
    wire  logic fail_val;
    wire  logic next_point;

    // an unheard point in a latest mode falls back to its high/low flavour
    assign unknown_val = (fail_default_in == DTPIO_DEF_LATEST_ON);
    assign fail_val =
        (fail_default_in == DTPIO_DEF_ON)  ? 1'b1 :
        (fail_default_in == DTPIO_DEF_OFF) ? 1'b0 :
        known ? held : unknown_val;
    // a disabled function never passes received states
    assign next_point = !enable_in ? 1'b0 :
        link_ok_in ? rx_bit_in : fail_val;

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            held      <= RESET_BIT;
            known     <= 1'b0;
            point_out <= RESET_BIT;
        end
        else
        begin
            if (enable_in && link_ok_in)
            begin
                held  <= rx_bit_in;
                known <= 1'b1;
            end
            point_out <= next_point;
        end
    end

    a_hold_freeze: assert property (@(posedge clock_in) disable iff (rst_in)
        enable_in && !link_ok_in && known
        && fail_default_in[1] |=> point_out == $past(held))
        else $error("hold-last point did not freeze");
    a_forced_on: assert property (@(posedge clock_in) disable iff (rst_in)
        enable_in && !link_ok_in && fail_default_in == DTPIO_DEF_ON
        |=> point_out)
        else $error("forced-on point not high on failure");
    a_forced_off: assert property (@(posedge clock_in) disable iff (rst_in)
        enable_in && !link_ok_in && fail_default_in == DTPIO_DEF_OFF
        |=> !point_out)
        else $error("forced-off point not low on failure");
    a_unknown_dflt: assert property (@(posedge clock_in) disable iff (rst_in)
        enable_in && !link_ok_in && !known && fail_default_in[1]
        |=> point_out == !$past(fail_default_in[0]))
        else $error("unheard latest point has wrong value");
    a_follow_rx: assert property (@(posedge clock_in) disable iff (rst_in)
        enable_in && link_ok_in |=> point_out == $past(rx_bit_in))
        else $error("healthy point does not follow received bit");
    a_disabled_low: assert property (@(posedge clock_in) disable iff (rst_in)
        !enable_in |=> !point_out)
        else $error("disabled point carries a state");
endmodule // dtpio_fail_hold

// File: dtpio_map.sv
// direct output selection, direct input extraction, teleprotection inputs
//
// Overview of operation
// - each direct output sends a selected operand
// - selected operand may be a direct input
// - direct input picks node and bit
// - sixteen teleprotection inputs on channel one
// - channel two inputs only in two-channel setups
// - disabled teleprotection carries no received states
// - forced-on default drives one on failure
// - forced-off default drives zero on failure
// - hold-last modes freeze last received value
// - unheard hold-last reads high or low flavour
// - restored link resumes following received values
// - input bit number equals sender output index
`timescale 1ns/1ps
module dtpio_map
    import dtpio_pkg::*;
(
    // clock and reset
    input  wire logic                          clock_in,
    input  wire logic                          rst_in,
    // local operands (same clock)
    input  wire logic [NUM_OPNDS-1:0]          operand_in,
    // direct output selection, one operand index per output
    input  wire logic [DIR_POINTS*OPND_W-1:0]  dir_out_select_in,
    output logic      [DIR_POINTS-1:0]         dir_tx_out,
    // received direct bits, one word per source node (from the link pins)
    input  wire logic [NUM_NODES*DIR_POINTS-1:0] dir_rx_bits_in,
    input  wire logic [NUM_NODES-1:0]          node_online_in,
    // direct input configuration
    input  wire logic [DIR_POINTS*NODE_W-1:0]  rx_source_node_id_in,
    input  wire logic [DIR_POINTS*BIT_W-1:0]   dir_in_bit_number_in,
    input  wire logic [DIR_POINTS*2-1:0]       dir_in_fail_default_in,
    output logic      [DIR_POINTS-1:0]         dir_in_on_out,
    // teleprotection
    input  wire logic                          tele_enable_in,
    input  wire logic                          two_channel_in,
    input  wire logic [TELE_POINTS-1:0]        tele_rx_ch1_in,
    input  wire logic [TELE_POINTS-1:0]        tele_rx_ch2_in,
    input  wire logic                          ch1_ok_in,
    input  wire logic                          ch2_ok_in,
    input  wire logic [TELE_POINTS*2-1:0]      tele_rx_fail_default_ch1_in,
    input  wire logic [TELE_POINTS*2-1:0]      tele_rx_fail_default_ch2_in,
    output logic      [TELE_POINTS-1:0]        tele_in_ch1_out,
    output logic      [TELE_POINTS-1:0]        tele_in_ch2_out
);
    // pin-side inputs are synchronised before use
    localparam int unsigned PIN_W = NUM_NODES*DIR_POINTS + NUM_NODES
        + 2*TELE_POINTS + 2;

    logic [PIN_W-1:0] pins_sync;
    logic [NUM_NODES*DIR_POINTS-1:0] rx_bits_s;
    logic [NUM_NODES-1:0]            online_s;
    logic [TELE_POINTS-1:0]          tele1_s;
    logic [TELE_POINTS-1:0]          tele2_s;
    logic                            ch1_ok_s;
    logic                            ch2_ok_s;

    dtpio_sync #(
        .WIDTH    (PIN_W)
    ) u_pin_sync (
        .clock_in (clock_in),
        .rst_in   (rst_in),
        .async_in ({dir_rx_bits_in, node_online_in, tele_rx_ch1_in,
                    tele_rx_ch2_in, ch1_ok_in, ch2_ok_in}),
        .sync_out (pins_sync)
    );

    assign {rx_bits_s, online_s, tele1_s, tele2_s, ch1_ok_s, ch2_ok_s} =
        pins_sync;

    // operand space: local operands, with the direct input points mapped
    // at the top so an output can forward a received point
    wire logic [NUM_OPNDS-1:0] opnd_space;
    assign opnd_space = {dir_in_on_out,
        operand_in[DIRIN_SEL_BASE-1:0]};

    genvar g;
    generate
        for (g = 0; g < DIR_POINTS; g++)
        begin : g_dir
            wire logic [OPND_W-1:0] sel;
            wire logic [NODE_W-1:0] node;
            wire logic [BIT_W-1:0]  bitn;
            wire logic [DIR_POINTS-1:0] node_word;
            wire logic rx_bit;
            wire logic link_ok;

            assign sel  = dir_out_select_in[g*OPND_W +: OPND_W];
            assign node = rx_source_node_id_in[g*NODE_W +: NODE_W];
            assign bitn = dir_in_bit_number_in[g*BIT_W +: BIT_W];
            assign node_word = rx_bits_s[node*DIR_POINTS +: DIR_POINTS];
            // bit number indexes the sender's output list directly
            assign rx_bit  = node_word[bitn];
            assign link_ok = online_s[node];

            always_ff @(posedge clock_in)
            begin
                if (rst_in)
                    dir_tx_out[g] <= RESET_BIT;
                else
                    dir_tx_out[g] <= opnd_space[sel[6:0]];
            end

            // direct inputs are always live; their enable is tied high
            dtpio_fail_hold u_dir_in (
                .clock_in        (clock_in),
                .rst_in          (rst_in),
                .enable_in       (1'b1),
                .link_ok_in      (link_ok),
                .rx_bit_in       (rx_bit),
                .fail_default_in (dir_in_fail_default_in[g*2 +: 2]),
                .point_out       (dir_in_on_out[g])
            );
        end
    endgenerate

    // channel two exists only in two-channel setups with teleprotection enabled
    wire logic ch2_enable;
    assign ch2_enable = tele_enable_in && two_channel_in;

    generate
        for (g = 0; g < TELE_POINTS; g++)
        begin : g_tele
            dtpio_fail_hold u_ch1 (
                .clock_in        (clock_in),
                .rst_in          (rst_in),
                .enable_in       (tele_enable_in),
                .link_ok_in      (ch1_ok_s),
                .rx_bit_in       (tele1_s[g]),
                .fail_default_in (tele_rx_fail_default_ch1_in[g*2 +: 2]),
                .point_out       (tele_in_ch1_out[g])
            );
            dtpio_fail_hold u_ch2 (
                .clock_in        (clock_in),
                .rst_in          (rst_in),
                .enable_in       (ch2_enable),
                .link_ok_in      (ch2_ok_s),
                .rx_bit_in       (tele2_s[g]),
                .fail_default_in (tele_rx_fail_default_ch2_in[g*2 +: 2]),
                .point_out       (tele_in_ch2_out[g])
            );
        end
    endgenerate

    // point 0 of each kind is watched closely; the points are one
    // replicated cell, so a fault in the shared wiring shows here too
    wire logic [NODE_W-1:0] dir0_node;
    wire logic [BIT_W-1:0]  dir0_bit;
    wire logic              dir0_live;
    wire logic              dir0_rx;
    wire logic [1:0]        dir0_code;
    wire logic [1:0]        ch1_code0;
    wire logic [1:0]        ch2_code0;

    assign dir0_node = rx_source_node_id_in[NODE_W-1:0];
    assign dir0_bit  = dir_in_bit_number_in[BIT_W-1:0];
    assign dir0_live = online_s[dir0_node];
    // node word and bit number concatenate into the flat received index
    assign dir0_rx   = rx_bits_s[{dir0_node, dir0_bit}];
    assign dir0_code = dir_in_fail_default_in[1:0];
    assign ch1_code0 = tele_rx_fail_default_ch1_in[1:0];
    assign ch2_code0 = tele_rx_fail_default_ch2_in[1:0];

    a_dir_in_pick: assert property (@(posedge clock_in) disable iff (rst_in)
        dir0_live |=> dir_in_on_out[0] == $past(dir0_rx))
        else $error("direct input 0 not taken from its node and bit");
    a_dir_in_on: assert property (@(posedge clock_in) disable iff (rst_in)
        !dir0_live && dir0_code == DTPIO_DEF_ON
        |=> dir_in_on_out[0])
        else $error("offline direct input 0 not forced high");
    a_dir_in_off: assert property (@(posedge clock_in) disable iff (rst_in)
        !dir0_live && dir0_code == DTPIO_DEF_OFF
        |=> !dir_in_on_out[0])
        else $error("offline direct input 0 not forced low");
    a_ch1_follow: assert property (@(posedge clock_in) disable iff (rst_in)
        tele_enable_in && ch1_ok_s
        |=> tele_in_ch1_out == $past(tele1_s))
        else $error("channel one points do not follow the link");
    a_ch1_off: assert property (@(posedge clock_in) disable iff (rst_in)
        !tele_enable_in |=> tele_in_ch1_out == '0)
        else $error("disabled channel one carries states");
    a_ch1_fail_on: assert property (@(posedge clock_in) disable iff (rst_in)
        tele_enable_in && !ch1_ok_s && ch1_code0 == DTPIO_DEF_ON
        |=> tele_in_ch1_out[0])
        else $error("failed channel one point 0 not forced high");
    a_ch1_fail_off: assert property (@(posedge clock_in) disable iff (rst_in)
        tele_enable_in && !ch1_ok_s && ch1_code0 == DTPIO_DEF_OFF
        |=> !tele_in_ch1_out[0])
        else $error("failed channel one point 0 not forced low");
    a_ch2_follow: assert property (@(posedge clock_in) disable iff (rst_in)
        ch2_enable && ch2_ok_s
        |=> tele_in_ch2_out == $past(tele2_s))
        else $error("channel two points do not follow the link");
    a_ch2_fail_off: assert property (@(posedge clock_in) disable iff (rst_in)
        ch2_enable && !ch2_ok_s && ch2_code0 == DTPIO_DEF_OFF
        |=> !tele_in_ch2_out[0])
        else $error("failed channel two point 0 not forced low");
    a_dir_tx_fwd: assert property (@(posedge clock_in) disable iff (rst_in)
        $stable(dir_out_select_in[255:248]) && $stable(opnd_space)
        |=> dir_tx_out[31] == $past(opnd_space[dir_out_select_in[254:248]]))
        else $error("direct output 31 does not carry its operand");
    a_dir_tx_sel: assert property (@(posedge clock_in) disable iff (rst_in)
        $stable(dir_out_select_in[7:0]) && $stable(opnd_space)
        |=> dir_tx_out[0] == $past(opnd_space[dir_out_select_in[6:0]]))
        else $error("direct output 0 does not carry its operand");
    a_ch2_absent: assert property (@(posedge clock_in) disable iff (rst_in)
        !two_channel_in |=> tele_in_ch2_out == '0)
        else $error("channel two points live in single channel setup");
endmodule // dtpio_map

// File: dtpio_far_model.sv
// remote relays and channels seen from the local point mapper
`timescale 1ns/1ps
module dtpio_far_model
    import dtpio_pkg::*;
(
    // control from bench
    input  wire logic                            clock_in,
    input  wire logic [1:0]                      ch_up_in,
    input  wire logic [TELE_POINTS-1:0]          ch1_send_in,
    input  wire logic [TELE_POINTS-1:0]          ch2_send_in,
    input  wire logic [NUM_NODES-1:0]            node_up_in,
    input  wire logic [NUM_NODES*DIR_POINTS-1:0] node_send_in,
    // link pins
    output logic      [TELE_POINTS-1:0]          tele_rx_ch1_out,
    output logic      [TELE_POINTS-1:0]          tele_rx_ch2_out,
    output logic      [1:0]                      ch_ok_out,
    output logic      [NUM_NODES*DIR_POINTS-1:0] dir_rx_bits_out,
    output logic      [NUM_NODES-1:0]            node_online_out
);
    initial
    begin
        {tele_rx_ch1_out, tele_rx_ch2_out, ch_ok_out} = '0;
        {dir_rx_bits_out, node_online_out} = '0;
    end
    // a dead link shows garbage, toggling so a stale value cannot pass
    always @(posedge clock_in)
    begin
        ch_ok_out <= ch_up_in;
        tele_rx_ch1_out <= ch_up_in[0] ? ch1_send_in : ~tele_rx_ch1_out;
        tele_rx_ch2_out <= ch_up_in[1] ? ch2_send_in : ~tele_rx_ch2_out;
        node_online_out <= node_up_in;
        for (int n = 0; n < NUM_NODES; n++)
            dir_rx_bits_out[n*DIR_POINTS+:DIR_POINTS] <= node_up_in[n] ?
                node_send_in[n*DIR_POINTS+:DIR_POINTS] :
                ~dir_rx_bits_out[n*DIR_POINTS+:DIR_POINTS];
    end
endmodule // dtpio_far_model

// File: dtpio_map_bench.sv
// self-checking bench for the direct / teleprotection point mapper
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin \
    mismatches++; $display("ERROR %s exp %h got %h", nm, ex, gt); end end
module dtpio_map_bench
    import dtpio_pkg::*;
;
    logic clock_in = 0, rst_in = 1, tele_enable = 1, two_ch = 0;
    logic [127:0] operand = '0;
    logic [255:0] sel = '0;
    logic [127:0] node_id = '0;
    logic [159:0] bitnum = '0;
    logic [63:0] ddef = {32{2'h1}};
    logic [31:0] def1 = '0, def2 = {16{2'h1}};
    logic [1:0] ch_up = '0, ch_ok;
    logic [15:0] s1 = '0, s2 = '0, rx1, rx2, t1, t2;
    logic [15:0] node_up = '0, online;
    logic [511:0] node_send = '0, rxb;
    logic [31:0] dtx, din;
    int mismatches = 0, num_checks = 0, cycles = 0;
    always #4 clock_in = ~clock_in;
    dtpio_far_model far (.clock_in(clock_in), .ch_up_in(ch_up),
        .ch1_send_in(s1), .ch2_send_in(s2), .node_up_in(node_up),
        .node_send_in(node_send), .tele_rx_ch1_out(rx1),
        .tele_rx_ch2_out(rx2), .ch_ok_out(ch_ok),
        .dir_rx_bits_out(rxb), .node_online_out(online));
    dtpio_map dut (.clock_in(clock_in), .rst_in(rst_in),
        .operand_in(operand), .dir_out_select_in(sel), .dir_tx_out(dtx),
        .dir_rx_bits_in(rxb), .node_online_in(online),
        .rx_source_node_id_in(node_id), .dir_in_bit_number_in(bitnum),
        .dir_in_fail_default_in(ddef), .dir_in_on_out(din),
        .tele_enable_in(tele_enable), .two_channel_in(two_ch),
        .tele_rx_ch1_in(rx1), .tele_rx_ch2_in(rx2),
        .ch1_ok_in(ch_ok[0]), .ch2_ok_in(ch_ok[1]),
        .tele_rx_fail_default_ch1_in(def1),
        .tele_rx_fail_default_ch2_in(def2),
        .tele_in_ch1_out(t1), .tele_in_ch2_out(t2));
    task results;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task wait_n(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task do_reset;
        @(posedge clock_in);
        rst_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        rst_in <= 1'b0;
    endtask
    task test_direct;
        @(posedge clock_in);
        operand <= 128'h0000_0000_8000_0000_0000_0000_0000_0020;
        wait_n(2);
        `CHK("dir tx", 32'h8000_0001, dtx)
        @(posedge clock_in);
        node_up <= 16'h0004;
        node_send <= 512'h1 << 76;
        wait_n(7);
        `CHK("dir in", 32'h0000_0020, din)
        `CHK("dir fwd", 32'h8000_0009, dtx)
        `CHK("permit and", 1'b0, din[5] & din[6])
        $display("test direct done");
    endtask
    // one fail-safe mode across all sixteen channel-one points
    task test_tele(input logic [1:0] m);
        logic [15:0] dflt;
        dflt = m[0] ? 16'h0000 : 16'hFFFF;
        @(posedge clock_in);
        def1 <= {16{m}};
        ch_up <= 2'h0;
        do_reset;
        wait_n(7);
        `CHK("tele unheard", dflt, t1)
        @(posedge clock_in);
        s1 <= 16'h8001;
        ch_up <= 2'h1;
        wait_n(7);
        `CHK("tele follow", 16'h8001, t1)
        @(posedge clock_in);
        ch_up <= 2'h0;
        wait_n(7);
        `CHK("tele fail", m[1] ? 16'h8001 : dflt, t1)
        @(posedge clock_in);
        s1 <= 16'h0001;
        ch_up <= 2'h1;
        wait_n(7);
        `CHK("tele restore", 16'h0001, t1)
        $display("test tele mode %0d done", m);
    endtask
    task test_chan;
        @(posedge clock_in);
        tele_enable <= 1'b0;
        ch_up <= 2'h3;
        s2 <= 16'hFFFF;
        wait_n(7);
        `CHK("tele off ch1", 16'h0000, t1)
        @(posedge clock_in);
        tele_enable <= 1'b1;
        wait_n(4);
        `CHK("one channel ch2", 16'h0000, t2)
        @(posedge clock_in);
        two_ch <= 1'b1;
        wait_n(4);
        `CHK("two channel ch2", 16'hFFFF, t2)
        $display("test channels done");
    endtask
    always @(posedge clock_in)
    begin
        cycles++;
        if (cycles == 1000)
        begin
            mismatches++;
            results();
        end
    end
    initial
    begin
        sel[0+:8] = 8'h05;
        sel[248+:8] = 8'h5F;
        sel[24+:8] = 8'h65;
        node_id[20+:4] = 4'h2;
        bitnum[25+:5] = 5'h0C;
        do_reset;
        test_direct;
        for (int m = 0; m < 4; m++)
            test_tele(m[1:0]);
        test_chan;
        results;
    end
endmodule // dtpio_map_bench
